/* logic/nps_sequencer.sv */
/*
  program/erase sequencer: control register, bus capture, pump control,
  self-timed cycle and the array itself.
  assumes a processor bus with one-cycle strobes and read data one cycle later;
  protect bits and the 35 us tick come from configuration logic on mclk_in.
*/
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
module nps_sequencer (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // processor bus
  input wire nps_pkg::nps_bus_t bus_in,
  output logic [7:0] rdata_out,
  // configuration inputs
  input wire logic [3:0] block_guard_bit_in,
  input wire logic timebase_tick_in,
  // pump and status
  output logic pump_on_out,
  output logic array_power_down_out
);
  import nps_pkg::*;

  logic rst_s1, rst_n;
  logic [7:0] ctrl;
  nps_capture_t cap;
  logic cap_valid;
  logic [9:0] tick_cnt;
  logic tick_d, tick_q, tick_pulse;
  logic [3:0] guard;
  logic rd_ctrl_q, rd_arr_q, rd_arr_armed_q;
  logic [7:0] arr_rdata;
  logic in_array, ctrl_hit, auto_done, apply;
  logic [7:0] wr_val, next_ctrl;
  logic [9:0] limit;
  nps_op_t op;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // tick and guards from configuration logic, same clock
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      guard <= 4'hF;
      tick_d <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      guard <= block_guard_bit_in;
      tick_d <= timebase_tick_in;
      tick_q <= tick_d;
    end
  end
  assign tick_pulse = tick_d & ~tick_q;

  assign in_array = (bus_in.addr >= ARRAY_BASE) && (bus_in.addr <= ARRAY_LAST);
  assign ctrl_hit = bus_in.wr && (bus_in.addr == CTRL_ADDR);
  assign op = nps_op_t'(ctrl[BIT_OPH:BIT_OPL]);

  always_comb begin
    case (op)
      OP_PROG: limit = PROG_TICKS;
      OP_BYTE_ERASE: limit = BYTE_TICKS;
      OP_BLOCK_ERASE: limit = BLOCK_TICKS;
      default: limit = BULK_TICKS;
    endcase
  end
  assign auto_done = ctrl[BIT_GO] && ctrl[BIT_AUTO] && tick_pulse && (tick_cnt + 10'h001 >= limit);

  // control register update
  always_comb begin
    next_ctrl = ctrl;
    wr_val = bus_in.wdata & CTRL_WMASK;
    if (ctrl_hit && (!ctrl[BIT_ARM] || cap_valid)) begin
      next_ctrl = wr_val;
      if (!(wr_val[BIT_ARM] && ctrl[BIT_ARM] && cap_valid)) begin
        next_ctrl[BIT_GO] = 1'b0;
      end
      if (ctrl[BIT_GO] && !wr_val[BIT_ARM]) begin
        next_ctrl[BIT_ARM] = 1'b1;
      end
    end
    if (auto_done) begin
      next_ctrl[BIT_GO] = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // capture of address and data while armed
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap <= '0;
      cap_valid <= 1'b0;
    end else if (!ctrl[BIT_ARM]) begin
      cap_valid <= 1'b0;
    end else if (in_array && !ctrl[BIT_GO]) begin
      if (bus_in.wr) begin
        cap.addr <= bus_in.addr[8:0];
        cap.data <= bus_in.wdata;
        cap_valid <= 1'b1;
      end else if (bus_in.rd) begin
        cap.addr <= bus_in.addr[8:0];
      end
    end
  end

  // self-timed counter
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 10'h000;
    end else if (!ctrl[BIT_GO] || auto_done) begin
      tick_cnt <= 10'h000;
    end else if (tick_pulse) begin
      tick_cnt <= tick_cnt + 10'h001;
    end
  end

  // operation is committed when the pump is switched off
  assign apply = ctrl[BIT_GO] && !next_ctrl[BIT_GO] && !ctrl[BIT_PDOWN];

  nps_cell_array u_array (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .raddr_in(bus_in.addr[8:0]),
    .rdata_out(arr_rdata),
    .apply_in(apply),
    .op_in(op),
    .cap_in(cap),
    .guard_in(guard)
  );

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_ctrl_q <= 1'b0;
      rd_arr_q <= 1'b0;
      rd_arr_armed_q <= 1'b0;
    end else begin
      rd_ctrl_q <= bus_in.rd && (bus_in.addr == CTRL_ADDR);
      rd_arr_q <= bus_in.rd && in_array && !ctrl[BIT_PDOWN];
      rd_arr_armed_q <= ctrl[BIT_ARM];
    end
  end

  // captured data held one cycle for the armed read path
  logic [7:0] cap_data_q;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_data_q <= 8'h00;
    end else begin
      cap_data_q <= cap.data;
    end
  end

  always_comb begin
    rdata_out = 8'h00;
    if (rd_ctrl_q) begin
      rdata_out = ctrl;
    end else if (rd_arr_q) begin
      rdata_out = rd_arr_armed_q ? cap_data_q : arr_rdata;
    end
  end

  assign pump_on_out = ctrl[BIT_GO];
  assign array_power_down_out = ctrl[BIT_PDOWN];

  // checks
  sequence go_request_s;
    ctrl_hit && bus_in.wdata[BIT_GO] && !(ctrl[BIT_ARM] && cap_valid);
  endsequence
  go_refused_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    go_request_s |=> !ctrl[BIT_GO]) else $error("enable set without arm and capture");
  arm_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl[BIT_GO] |=> ctrl[BIT_ARM]) else $error("arm cleared while enable set");
  auto_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    auto_done |=> !pump_on_out) else $error("self-timed end did not drop pump");
  capture_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl[BIT_ARM] && !ctrl[BIT_GO] && bus_in.wr && in_array |=> cap_valid && cap.data == $past(bus_in.wdata))
    else $error("array write not captured");
  no_capture_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !in_array && !bus_in.rd |=> $stable(cap.addr) || !$past(ctrl[BIT_ARM])) else $error("capture from outside array");
  ctrl_block_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl[BIT_ARM] && !cap_valid && !ctrl[BIT_GO] |=> ctrl[BIT_ARM]) else $error("control write taken before capture");
  pump_cause_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $rose(pump_on_out) |-> $past(cap_valid) && $past(ctrl[BIT_ARM])) else $error("pump on without capture");
  spare_bit_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl_hit && !ctrl[BIT_ARM] |=> ctrl[BIT_SPARE] == $past(bus_in.wdata[BIT_SPARE])) else $error("bit seven not stored");
endmodule : nps_sequencer

/* logic/nps_pkg.sv */
/*
  constants and carrier types for the nonvolatile program/erase sequencer.
  assumes a single bus clock domain and an external 35 us timebase tick.
*/
// Overview of operation
// - erased cells read one, program clears only
// - program clears bits written zero, one byte
// - erase covers byte, block or array
// - self-timed mode ends cycle, clears enable
// - protected blocks stay unchanged
// - capture only array-range writes while armed
// - control writes ignored until array capture
// - latest array write overrides earlier capture
// - armed array read returns data, latches address
// - enable refused without arm and capture
// - clearing enable and arm clears enable only
// - arm cannot clear while enable set
// - power-down bit disables array access
// - two-bit mode field, protect suppresses operation
// - pump on only when armed and captured
// - control bit seven is plain storage
// - block erase spans block, bulk spans array
// - 512 bytes in four 128-byte blocks
// - timing counted in 35 us ticks
package nps_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] ARRAY_BASE = 16'h0800;
  localparam logic [15:0] ARRAY_LAST = 16'h09FF;
  localparam logic [15:0] CTRL_ADDR = 16'hFE1D;
  localparam int ARRAY_BYTES = 512;
  localparam int BLOCK_BYTES = 128;
  localparam int NUM_BLOCKS = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // control register bit positions
  localparam int BIT_SPARE = 7;
  localparam int BIT_PDOWN = 5;
  localparam int BIT_OPH = 4;
  localparam int BIT_OPL = 3;
  localparam int BIT_ARM = 2;
  localparam int BIT_AUTO = 1;
  localparam int BIT_GO = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hBF;
  // self-timed durations in timebase ticks
  localparam int TICK_US = 35;
  localparam logic [9:0] PROG_TICKS = 10'h09F;
  localparam logic [9:0] BYTE_TICKS = 10'h09F;
  localparam logic [9:0] BLOCK_TICKS = 10'h09F;
  localparam logic [9:0] BULK_TICKS = 10'h09F;
  typedef enum logic [1:0] {
    OP_PROG = 2'h0,
    OP_BYTE_ERASE = 2'h1,
    OP_BLOCK_ERASE = 2'h2,
    OP_BULK_ERASE = 2'h3
  } nps_op_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nps_bus_t;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } nps_capture_t;
endpackage : nps_pkg

/* logic/nps_cell_array.sv */
/*
  byte array with program (clear-only) and erase (set to ff) operations.
  resolves protection itself, per 128-byte block, from guard_in.
*/
`timescale 1ns/10ps
module nps_cell_array (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // read port
  input wire logic [8:0] raddr_in,
  output logic [7:0] rdata_out,
  // operation port
  input wire logic apply_in,
  input wire nps_pkg::nps_op_t op_in,
  input wire nps_pkg::nps_capture_t cap_in,
  input wire logic [3:0] guard_in
);
  import nps_pkg::*;
  logic [7:0] mem [0:ARRAY_BYTES-1];
  // no reset on storage: nonvolatile content, erased at power-on
  initial begin
    for (int i = 0; i < ARRAY_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end
  always_ff @(posedge clk_in) begin
    if (apply_in) begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        if (!guard_in[i / BLOCK_BYTES]) begin
          case (op_in)
            OP_PROG: begin
              if (i == int'(cap_in.addr)) begin
                mem[i] <= mem[i] & cap_in.data;
              end
            end
            OP_BYTE_ERASE: begin
              if (i == int'(cap_in.addr)) begin
                mem[i] <= ERASED_BYTE;
              end
            end
            OP_BLOCK_ERASE: begin
              if ((i / BLOCK_BYTES) == int'(cap_in.addr[8:7])) begin
                mem[i] <= ERASED_BYTE;
              end
            end
            default: begin
              mem[i] <= ERASED_BYTE;
            end
          endcase
        end
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule : nps_cell_array

/* testbench/nps_bus_master.sv */
/*
  processor bus model: one-cycle write and read strobes, software program/erase sequence.
  assumes the sequencer never stalls and read data stand only in the cycle after the read.
*/
`timescale 1ns/10ps
module nps_bus_master (
  // clock
  input wire logic mclk_in,
  // bus
  output nps_pkg::nps_bus_t bus_out,
  input wire logic [7:0] rdata_in
);
  import nps_pkg::*;
  initial bus_out = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_out.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_out.rd <= 1'b0;
    @(negedge mclk_in);
    d = rdata_in;
  endtask : rd
  // software-timed sequence; no array read while the enable bit is set
  task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
    wr(CTRL_ADDR, {3'h0, m, 3'h4});
    wr(a, d);
    wr(CTRL_ADDR, {3'h0, m, 3'h5});
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h00);
  endtask : op
endmodule : nps_bus_master

/* testbench/nps_sequencer_tb.sv */
/*
  self-checking bench for the program/erase sequencer.
  assumes a 25 MHz bus clock; protect bits and timebase ticks are driven here.
*/
`timescale 1ns/10ps
module nps_sequencer_tb;
  import nps_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic timebase_tick_in = 1'b0;
  logic [3:0] block_guard_bit_in = 4'h0;
  nps_bus_t bus;
  logic [7:0] rdata;
  logic [7:0] v;
  logic pump;
  logic pdown;
  int failures = 0;
  int comparisons = 0;
  int n;
  always #20 mclk_in = ~mclk_in;
  nps_sequencer DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata),
    .block_guard_bit_in(block_guard_bit_in), .timebase_tick_in(timebase_tick_in),
    .pump_on_out(pump), .array_power_down_out(pdown));
  nps_bus_master BUS (.mclk_in(mclk_in), .bus_out(bus), .rdata_in(rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    BUS.rd(a, v);
    check(v, exp);
  endtask : rchk
  task automatic pchk(input logic exp);
    @(negedge mclk_in);
    check({7'h00, pump}, {7'h00, exp});
  endtask : pchk
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rchk(CTRL_ADDR, 8'h00);
    rchk(16'h0810, ERASED_BYTE);
    check({6'h00, pump, pdown}, 8'h00);
    $display("test reset done");
    BUS.wr(CTRL_ADDR, 8'hE0);
    rchk(CTRL_ADDR, 8'hA0);
    check({7'h00, pdown}, 8'h01);
    BUS.wr(CTRL_ADDR, 8'h01);
    rchk(CTRL_ADDR, 8'h00);
    pchk(1'b0);
    $display("test control done");
    BUS.wr(CTRL_ADDR, 8'h04);
    BUS.wr(CTRL_ADDR, 8'h0D);
    BUS.wr(16'h0A00, 8'h00);
    BUS.wr(CTRL_ADDR, 8'h05);
    rchk(CTRL_ADDR, 8'h04);
    BUS.wr(16'h0811, 8'h00);
    BUS.wr(16'h0813, 8'hFE);
    // armed read returns the captured data and moves the target to the read address
    rchk(16'h0810, 8'hFE);
    BUS.wr(CTRL_ADDR, 8'h05);
    pchk(1'b1);
    BUS.wr(CTRL_ADDR, 8'h00);
    pchk(1'b0);
    rchk(CTRL_ADDR, 8'h04);
    BUS.wr(CTRL_ADDR, 8'h00);
    rchk(16'h0810, 8'hFE);
    rchk(16'h0811, 8'hFF);
    rchk(16'h0813, 8'hFF);
    $display("test manual program done");
    BUS.wr(CTRL_ADDR, 8'h06);
    BUS.wr(16'h0810, 8'hFD);
    BUS.wr(CTRL_ADDR, 8'h07);
    @(negedge mclk_in);
    // ticks spaced apart so a late pump drop is not charged to the next tick
    for (n = 0; n < 400 && pump === 1'b1; n++) begin
      @(posedge mclk_in) timebase_tick_in <= 1'b1;
      @(posedge mclk_in) timebase_tick_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      @(negedge mclk_in);
    end
    if (n == 400) begin
      failures++;
    end
    check(n[7:0], PROG_TICKS[7:0]);
    rchk(CTRL_ADDR, 8'h06);
    BUS.wr(CTRL_ADDR, 8'h00);
    rchk(16'h0810, 8'hFC);
    $display("test self-timed program done");
    BUS.op(2'h1, 16'h0810, 8'h00);
    rchk(16'h0810, 8'hFF);
    BUS.op(2'h0, 16'h0811, 8'h00);
    BUS.op(2'h0, 16'h0900, 8'h00);
    BUS.op(2'h2, 16'h0850, 8'h00);
    rchk(16'h0811, 8'hFF);
    rchk(16'h0900, 8'h00);
    @(posedge mclk_in) block_guard_bit_in <= 4'h5;
    BUS.op(2'h0, 16'h0812, 8'h00);
    rchk(16'h0812, 8'hFF);
    BUS.op(2'h3, 16'h0800, 8'h00);
    rchk(16'h0900, 8'h00);
    @(posedge mclk_in) block_guard_bit_in <= 4'h0;
    BUS.op(2'h3, 16'h09FF, 8'h00);
    rchk(16'h0900, 8'hFF);
    $display("test erase modes done");
    // reset in mid-run with the capture armed
    BUS.wr(CTRL_ADDR, 8'h04);
    @(posedge mclk_in) rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rchk(CTRL_ADDR, 8'h00);
    rchk(16'h0900, 8'hFF);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : nps_sequencer_tb
